// ---- agq_defines.svh ----
`ifndef AGQ_DEFINES_SVH
`define AGQ_DEFINES_SVH
`define AG_CTRL 8'h00
`define AG_GRANT 8'h04
`define AG_CAP 8'h08
`define AG_STAT 8'h0C
`define AG_MASK 8'h10
`define AG_AUX 8'h14
`define AG_F2_POS 8
`define AG_FLAG_POS 24
`define AG_ST_W 5
`define AG_ST_GRANT 0
`define AG_ST_GERR 1
`define AG_ST_CAP 2
`define AG_ST_CERR 3
`define AG_ST_ODD 4
`define AG_CL_MIN 8'h01
`define AG_CL_MAX 8'hFE
`define AG_TY_MIN 16'h0001
`define AG_CAP_MIN 7'h01
`define AG_CAP_MAX 7'h63
`define AG_CL_LEN 3'h2
`define AG_TY_LEN 3'h4
`define AG_ASW_EXT 19
`define AG_CH_0 8'h30
`define AG_CH_9 8'h39
`define AG_CH_A 8'h41
`define AG_CH_F 8'h46
`define AG_TEN 8'h0A
`endif

// ---- agq_pkg.sv ----
package agq_pkg;
`include "agq_defines.svh"

typedef enum logic [2:0] {
    agq_announcement_grant_msg,
    agq_config_capacity_msg,
    agq_config_name_list_msg,
    agq_fig_file_capacity_msg,
    agq_fig_file_name_list_msg,
    agq_counter_msg
} agq_cmd_e;

typedef enum logic [2:0] {
    agq_definition_ext,
    agq_query_ext,
    agq_record_ext,
    agq_end_ext,
    agq_error_ext
} agq_ext_e;

// Fields travel as text, right aligned: the last character sits in bits 7:0.
typedef struct packed {
    agq_cmd_e cmd;
    agq_ext_e ext;
    logic [31:0] field1;
    logic [2:0] len1;
    logic [31:0] field2;
    logic [2:0] len2;
} agq_msg_s;

function automatic logic [7:0] agq_hex_char(input logic [3:0] n);
    agq_hex_char = ({4'h0, n} < `AG_TEN) ? `AG_CH_0 + {4'h0, n} : `AG_CH_A - `AG_TEN + {4'h0, n};
endfunction

// Bit 4 flags a character that is not an upper-case hex digit.
function automatic logic [4:0] agq_hex_val(input logic [7:0] c);
    if (c >= `AG_CH_0 && c <= `AG_CH_9) begin
        agq_hex_val = {1'b0, 4'(c - `AG_CH_0)};
    end else if (c >= `AG_CH_A && c <= `AG_CH_F) begin
        agq_hex_val = {1'b0, 4'(c - `AG_CH_A + `AG_TEN)};
    end else begin
        agq_hex_val = 5'h10;
    end
endfunction

// Returns the length in bits 34:32 and the characters below.
function automatic logic [34:0] agq_dec_enc(input logic [6:0] v);
    logic [7:0] tens;
    logic [7:0] ones;
    tens = 8'({1'b0, v} / `AG_TEN);
    ones = {1'b0, v} - 8'(tens * `AG_TEN);
    if (tens == 8'h00) begin
        agq_dec_enc = {3'h1, 24'h000000, 8'(`AG_CH_0 + ones)};
    end else begin
        agq_dec_enc = {3'h2, 16'h0000, 8'(`AG_CH_0 + tens), 8'(`AG_CH_0 + ones)};
    end
endfunction

// Bit 7 flags a bad length or a non-digit.
function automatic logic [7:0] agq_dec_val(input logic [31:0] f, input logic [2:0] n);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = (n == 3'h2) ? f[15:8] - `AG_CH_0 : 8'h00;
    lo = f[7:0] - `AG_CH_0;
    agq_dec_val = {(n != 3'h1 && n != 3'h2) || hi >= `AG_TEN || lo >= `AG_TEN,
        7'(hi * `AG_TEN + lo)};
endfunction
endpackage

// ---- agq_link_if.sv ----
`timescale 1ns/1ps
interface agq_link_if;
    logic session;
    logic up_valid;
    logic up_ready;
    agq_pkg::agq_msg_s up_msg;
    logic dn_valid;
    logic dn_ready;
    agq_pkg::agq_msg_s dn_msg;
    modport downstream_end(output session, input up_valid, input up_msg, output up_ready,
        output dn_valid, output dn_msg, input dn_ready);
    modport upstream_end(input session, output up_valid, output up_msg, input up_ready,
        input dn_valid, input dn_msg, output dn_ready);
endinterface

// ---- agq_upstream_end.sv ----
`timescale 1ns/1ps
`include "agq_defines.svh"
module agq_upstream_end
    import agq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    agq_link_if.upstream_end link
);
    logic dph_wr, wr_en, rx_take, is_grant, is_cap, grant_bad, cap_bad, qreq, query_out;
    logic [7:0] dph_addr;
    logic [7:0] dmax;
    logic [7:0] dused;
    logic [7:0] last_cl;
    logic [15:0] last_ty;
    logic [6:0] cap_max;
    logic [6:0] cap_used;
    logic [31:0] figmask;
    logic [255:0] seen;
    logic [47:0] rx_chars;
    logic [5:0] bad_char;
    logic [23:0] rx_val;
    logic [`AG_ST_W-1:0] status;
    logic [`AG_ST_W-1:0] mask;
    logic [`AG_ST_W-1:0] st_set;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            dph_wr <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h000000;
            dph_addr <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end
    assign wr_en = dph_wr;

    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                `AG_CTRL: rd_mux = {31'h0, query_out};
                `AG_GRANT: rd_mux = {7'h0, !figmask[`AG_ASW_EXT], last_ty, last_cl};
                `AG_CAP: rd_mux = {17'h0, cap_used, 1'b0, cap_max};
                `AG_STAT: rd_mux = {{(32-`AG_ST_W){1'b0}}, status};
                `AG_MASK: rd_mux = {{(32-`AG_ST_W){1'b0}}, mask};
                `AG_AUX: rd_mux = figmask;
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoding runs straight off the link; parsing is character based.
    assign rx_chars = {link.dn_msg.field1[15:0], link.dn_msg.field2};
    for (genvar i = 0; i < 6; i++) begin : g_hex
        assign {bad_char[i], rx_val[4*i +: 4]} = agq_hex_val(rx_chars[8*i +: 8]);
    end
    assign rx_take = link.dn_valid && link.dn_ready;
    assign is_grant = link.dn_msg.cmd == agq_announcement_grant_msg
        && link.dn_msg.ext == agq_definition_ext;
    assign is_cap = link.dn_msg.cmd == agq_config_capacity_msg
        && link.dn_msg.ext == agq_definition_ext;
    assign grant_bad = !link.session || link.dn_msg.len1 != `AG_CL_LEN
        || link.dn_msg.len2 != `AG_TY_LEN || |bad_char
        || rx_val[23:16] < `AG_CL_MIN || rx_val[23:16] > `AG_CL_MAX
        || rx_val[15:0] < `AG_TY_MIN || seen[rx_val[23:16]];
    assign dmax = agq_dec_val(link.dn_msg.field1, link.dn_msg.len1);
    assign dused = agq_dec_val(link.dn_msg.field2, link.dn_msg.len2);
    assign cap_bad = !query_out || dmax[7] || dused[7]
        || dmax[6:0] < `AG_CAP_MIN || dmax[6:0] > `AG_CAP_MAX
        || dused[6:0] > dmax[6:0];
    assign qreq = wr_en && dph_addr == `AG_CTRL && hwdata[0] && !query_out;

    // This end has no path that builds a grant message at all.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.up_valid <= 1'b0;
            link.up_msg <= '0;
            link.dn_ready <= 1'b1;
            query_out <= 1'b0;
        end else if (ce) begin
            if (qreq) begin
                link.up_valid <= 1'b1;
                link.up_msg <= '{agq_config_capacity_msg, agq_query_ext, 32'h0, 3'h0, 32'h0, 3'h0};
            end else if (link.up_ready) begin
                link.up_valid <= 1'b0;
            end
            if (qreq) begin
                query_out <= 1'b1;
            end else if (rx_take && is_cap) begin
                query_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_cl <= 8'h00;
            last_ty <= 16'h0000;
            cap_max <= 7'h00;
            cap_used <= 7'h00;
            seen <= '0;
        end else if (ce) begin
            if (!link.session) begin
                seen <= '0;
            end else if (rx_take && is_grant && !grant_bad) begin
                seen[rx_val[23:16]] <= 1'b1;
                last_cl <= rx_val[23:16];
                last_ty <= rx_val[15:0];
            end
            if (rx_take && is_cap && !cap_bad) begin
                cap_max <= dmax[6:0];
                cap_used <= dused[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_set = '0;
        st_set[`AG_ST_GRANT] = rx_take && is_grant && !grant_bad;
        st_set[`AG_ST_GERR] = rx_take && is_grant && grant_bad;
        st_set[`AG_ST_CAP] = rx_take && is_cap && !cap_bad;
        st_set[`AG_ST_CERR] = rx_take && is_cap && cap_bad;
        st_set[`AG_ST_ODD] = rx_take && !is_grant && !is_cap;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            mask <= '0;
            figmask <= 32'h00000000;
            irq <= 1'b0;
        end else if (ce) begin
            status <= (status & ~((wr_en && dph_addr == `AG_STAT) ? hwdata[`AG_ST_W-1:0] : '0))
                | st_set;
            irq <= |(status & mask);
            if (wr_en && dph_addr == `AG_MASK) begin
                mask <= hwdata[`AG_ST_W-1:0];
            end
            if (wr_en && dph_addr == `AG_AUX) begin
                figmask <= hwdata;
            end
        end
    end
endmodule

// ---- agq_downstream_end.sv ----
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "agq_defines.svh"
// Behaviour
// - Only the downstream end sends grants.
// - Grants only while resource session open.
// - Each cluster granted once per session.
// - Cluster is two hex characters, 01..FE.
// - Clusters 00 and FF never granted.
// - Types are four hex characters, 0001..FFFF.
// - Grant usable only if extension 19 unblocked.
// - Fields are counted and carried as characters.
// - Catalogue of capacity, name and counter groups.
// - Capacity query is answered with capacity reply.
// - Capacity reply only answers a received query.
// - Maximum count is 1..99, one or two digits.
// - Used count is 0..maximum, one or two digits.
// - Counter reply carries frame, data count, time; neither end sends one.
// - Extension mask bit set means blocked.
module agq_downstream_end
    import agq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    agq_link_if.downstream_end link
);
    logic dph_wr;
    logic wr_en;
    logic [7:0] dph_addr;
    logic [6:0] cap_max;
    logic [6:0] cap_used;
    logic [`AG_ST_W-1:0] status;
    logic [`AG_ST_W-1:0] mask;
    logic [`AG_ST_W-1:0] st_set;
    logic [255:0] granted;
    logic [7:0] grant_cnt;
    logic grant_pend;
    logic [7:0] grant_cl;
    logic [15:0] grant_ty;
    logic answer_pend;
    logic grant_req;
    logic grant_ok;
    logic grant_drop;
    logic tx_free;
    logic load_answer;
    logic load_grant;
    logic rx_take;
    logic rx_query;
    logic [6:0] ans_max;
    logic [6:0] ans_used;
    logic [34:0] enc_max;
    logic [34:0] enc_used;
    logic [7:0] req_cl;
    logic [15:0] req_ty;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Zero wait states: read data is picked in the address phase and held
    // in a flop, so hrdata is stable for the whole data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            dph_wr <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h000000;
            dph_addr <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end
    assign wr_en = dph_wr;

    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                `AG_CTRL: rd_mux = {31'h0, link.session};
                `AG_GRANT: rd_mux = {7'h0, grant_pend, grant_ty, grant_cl};
                `AG_CAP: rd_mux = {17'h0, cap_used, 1'b0, cap_max};
                `AG_STAT: rd_mux = {{(32-`AG_ST_W){1'b0}}, status};
                `AG_MASK: rd_mux = {{(32-`AG_ST_W){1'b0}}, mask};
                `AG_AUX: rd_mux = {24'h0, grant_cnt};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.session <= 1'b0;
            cap_max <= `AG_CAP_MIN;
            cap_used <= 7'h00;
            mask <= '0;
        end else if (ce && wr_en) begin
            case (dph_addr)
                `AG_CTRL: link.session <= hwdata[0];
                `AG_CAP: begin
                    cap_max <= hwdata[6:0];
                    cap_used <= hwdata[`AG_F2_POS +: 7];
                end
                `AG_MASK: mask <= hwdata[`AG_ST_W-1:0];
                default: mask <= mask;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // A request is checked when software writes it, not when it leaves,
    // so a refusal shows in the status word in the very next cycle.
    assign req_cl = hwdata[7:0];
    assign req_ty = hwdata[`AG_F2_POS +: 16];
    assign grant_req = wr_en && dph_addr == `AG_GRANT;
    assign grant_ok = link.session && !grant_pend
        && req_cl >= `AG_CL_MIN && req_cl <= `AG_CL_MAX
        && !granted[req_cl]
        && req_ty >= `AG_TY_MIN;
    assign grant_drop = grant_pend && !link.session;
    assign tx_free = !link.dn_valid || link.dn_ready;
    assign load_answer = tx_free && answer_pend;
    assign load_grant = tx_free && !answer_pend && grant_pend && link.session;
    assign rx_take = link.up_valid && link.up_ready;
    assign rx_query = link.up_msg.cmd == agq_config_capacity_msg
        && link.up_msg.ext == agq_query_ext;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_pend <= 1'b0;
            grant_cl <= 8'h00;
            grant_ty <= 16'h0000;
            granted <= '0;
            grant_cnt <= 8'h00;
        end else if (ce) begin
            if (!link.session) begin
                granted <= '0;
                grant_cnt <= 8'h00;
            end else if (grant_req && grant_ok) begin
                granted[req_cl] <= 1'b1;
                grant_cnt <= grant_cnt + 8'h01;
            end
            if (grant_req && grant_ok) begin
                grant_pend <= 1'b1;
                grant_cl <= req_cl;
                grant_ty <= req_ty;
            end else if (load_grant || grant_drop) begin
                grant_pend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored figures outside the legal range are clamped before they are
    // sent, so the far end never sees an illegal reply; the clamp is flagged.
    assign ans_max = (cap_max < `AG_CAP_MIN) ? `AG_CAP_MIN
        : ((cap_max > `AG_CAP_MAX) ? `AG_CAP_MAX : cap_max);
    assign ans_used = (cap_used > ans_max) ? ans_max : cap_used;
    assign enc_max = agq_dec_enc(ans_max);
    assign enc_used = agq_dec_enc(ans_used);

    // Ready drops while a reply is owed: one query is served at a time,
    // and the reply only ever follows a query taken here.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.up_ready <= 1'b1;
            answer_pend <= 1'b0;
            link.dn_valid <= 1'b0;
            link.dn_msg <= '0;
        end else if (ce) begin
            if (rx_take && rx_query) begin
                answer_pend <= 1'b1;
                link.up_ready <= 1'b0;
            end else if (load_answer) begin
                answer_pend <= 1'b0;
                link.up_ready <= 1'b1;
            end
            if (load_answer) begin
                link.dn_valid <= 1'b1;
                link.dn_msg <= '{agq_config_capacity_msg, agq_definition_ext,
                    enc_max[31:0], enc_max[34:32], enc_used[31:0], enc_used[34:32]};
            end else if (load_grant) begin
                link.dn_valid <= 1'b1;
                link.dn_msg <= '{agq_announcement_grant_msg, agq_definition_ext,
                    {16'h0000, agq_hex_char(grant_cl[7:4]), agq_hex_char(grant_cl[3:0])},
                    `AG_CL_LEN,
                    {agq_hex_char(grant_ty[15:12]), agq_hex_char(grant_ty[11:8]),
                    agq_hex_char(grant_ty[7:4]), agq_hex_char(grant_ty[3:0])},
                    `AG_TY_LEN};
            end else if (tx_free) begin
                link.dn_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set wins over a write-one clear in the same cycle.
    always_comb begin
        st_set = '0;
        st_set[`AG_ST_GRANT] = load_grant;
        st_set[`AG_ST_GERR] = (grant_req && !grant_ok) || grant_drop;
        st_set[`AG_ST_CAP] = load_answer;
        st_set[`AG_ST_CERR] = load_answer && (ans_max != cap_max || ans_used != cap_used);
        st_set[`AG_ST_ODD] = rx_take && !rx_query;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            status <= (status & ~((wr_en && dph_addr == `AG_STAT) ? hwdata[`AG_ST_W-1:0] : '0))
                | st_set;
            irq <= |(status & mask);
        end
    end
endmodule

// ---- agq_link_properties.sv ----
`timescale 1ns/1ps
module agq_link_properties
    import agq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic session,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire agq_msg_s up_msg,
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire agq_msg_s dn_msg
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
////////////////////////////////////////////////////////////////////////////////
function automatic logic [3:0] hx(input logic [7:0] c);
    return 4'(c > 8'h39 ? c - 8'h37 : c - 8'h30);
endfunction
function automatic logic [7:0] dv(input logic [31:0] f, input logic [2:0] n);
    return 8'(n == 3'h2 ? (f[15:8] - 8'h30) * 8'h0A : 8'h00) + f[7:0] - 8'h30;
endfunction
logic gv;
logic cv;
logic qv;
logic q_open;
logic [7:0] cl;
logic [255:0] seen;
assign gv = dn_valid && dn_ready && dn_msg.cmd == agq_announcement_grant_msg;
assign cv = dn_valid && dn_msg.cmd == agq_config_capacity_msg && dn_msg.ext == agq_definition_ext;
assign qv = up_valid && up_ready && up_msg.cmd == agq_config_capacity_msg
    && up_msg.ext == agq_query_ext;
assign cl = {hx(dn_msg.field1[15:8]), hx(dn_msg.field1[7:0])};
// Cluster memory follows the session, so a reopened session may reuse a cluster.
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        seen <= '0;
    end else if (!session) begin
        seen <= '0;
    end else if (gv) begin
        seen[cl] <= 1'b1;
    end
end
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        q_open <= 1'b0;
    end else if (qv) begin
        q_open <= 1'b1;
    end else if (cv && dn_ready) begin
        q_open <= 1'b0;
    end
end
////////////////////////////////////////////////////////////////////////////////
a_no_up_grant:
    assert property (up_valid |-> up_msg.cmd != agq_announcement_grant_msg)
    else $error("grant sent by upstream end");
a_grant_in_session:
    assert property (gv |-> session) else $error("grant outside session");
a_cluster_once:
    assert property (gv |-> !seen[cl]) else $error("cluster granted twice");
a_cluster_range:
    assert property (gv |-> dn_msg.len1 == 3'h2 && cl >= 8'h01 && cl <= 8'hFE)
    else $error("bad cluster field");
a_type_field:
    assert property (gv |-> dn_msg.len2 == 3'h4 && dn_msg.field2 != 32'h30303030)
    else $error("bad type field");
a_query_answered:
    assert property (qv |-> ##[1:40] cv) else $error("query not answered");
a_reply_solicited:
    assert property (cv |-> q_open) else $error("unsolicited capacity reply");
a_max_range:
    assert property (cv |-> (dn_msg.len1 == 3'h1 || (dn_msg.len1 == 3'h2
        && dn_msg.field1[15:8] != 8'h30)) && dv(dn_msg.field1, dn_msg.len1) >= 8'h01
        && dv(dn_msg.field1, dn_msg.len1) <= 8'h63) else $error("bad maximum count");
a_used_range:
    assert property (cv |-> dv(dn_msg.field2, dn_msg.len2) <= dv(dn_msg.field1, dn_msg.len1))
    else $error("used count above maximum");
c_grant: cover property (gv);
c_query: cover property (qv ##[1:40] cv);
c_two_grants: cover property (gv ##[1:60] gv);
c_counter: cover property (dn_valid && dn_msg.cmd == agq_counter_msg);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "agq_defines.svh"
module tb_top;
    import agq_pkg::*;
    logic hclk;
    logic hresetn;
    logic ce;
    logic sess;
    logic [1:0] hsel;
    logic [1:0] hwrite;
    logic [1:0] hrdy;
    logic [1:0] irq;
    logic [31:0] haddr [2];
    logic [1:0] htrans [2];
    logic [31:0] hwdata [2];
    logic [31:0] hrdata [2];
    logic [31:0] seed;
    logic [255:0] used_cl;
    int errors;
    int checks_done;
    int n_ok;
    agq_link_if link();
    agq_downstream_end u_agq_downstream_end(.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel[0]), .haddr(haddr[0]), .htrans(htrans[0]), .hwrite(hwrite[0]), .hsize(3'h2),
        .hwdata(hwdata[0]), .hready(hrdy[0]), .hrdata(hrdata[0]), .hreadyout(hrdy[0]),
        .hresp(), .irq(irq[0]), .link(link.downstream_end));
    agq_upstream_end u_agq_upstream_end(.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel[1]), .haddr(haddr[1]), .htrans(htrans[1]), .hwrite(hwrite[1]), .hsize(3'h2),
        .hwdata(hwdata[1]), .hready(hrdy[1]), .hrdata(hrdata[1]), .hreadyout(hrdy[1]),
        .hresp(), .irq(irq[1]), .link(link.upstream_end));
    agq_link_properties u_agq_link_properties(.hclk(hclk), .hresetn(hresetn),
        .session(link.session), .up_valid(link.up_valid), .up_ready(link.up_ready),
        .up_msg(link.up_msg), .dn_valid(link.dn_valid), .dn_ready(link.dn_ready),
        .dn_msg(link.dn_msg));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_rdy(input int e);
        int n;
        n = 0;
        @(posedge hclk);
        while (hrdy[e] !== 1'b1) begin
            n++;
            if (n > 50) begin
                check("hready wait", 32'h0, 32'h1);
                test_done();
            end
            @(posedge hclk);
        end
    endtask
    // The address phase is held until hready is seen, so a slow slave is still served.
    task automatic bus(input int e, input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel[e] <= 1'b1;
        htrans[e] <= 2'b10;
        haddr[e] <= a;
        hwrite[e] <= w;
        wait_rdy(e);
        hsel[e] <= 1'b0;
        htrans[e] <= 2'b00;
        hwdata[e] <= d;
        wait_rdy(e);
        r = hrdata[e];
    endtask
    task automatic wr(input int e, input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(e, 1'b1, a, d, r);
    endtask
    task automatic rd(input int e, input logic [31:0] a, output logic [31:0] r);
        bus(e, 1'b0, a, 32'h0, r);
    endtask
    task automatic poll(input int e, input logic [31:0] m, output logic [31:0] r);
        int n;
        n = 0;
        rd(e, `AG_STAT, r);
        while ((r & m) === 32'h0) begin
            n++;
            if (n > 40) begin
                check("status wait", r, m);
                test_done();
            end
            rd(e, `AG_STAT, r);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic grant(input logic [7:0] cl, input logic [15:0] ty);
        logic [31:0] r;
        logic [31:0] aux;
        logic ok;
        aux = rnd();
        ok = sess && cl != 8'h00 && cl != 8'hFF && ty != 16'h0 && !used_cl[cl];
        wr(1, `AG_AUX, aux);
        wr(0, `AG_GRANT, {8'h00, ty, cl});
        poll(0, 32'h3, r);
        check("down status", r, ok ? 32'h1 : 32'h2);
        check("down irq", {31'h0, irq[0]}, {31'h0, !ok});
        wr(0, `AG_STAT, 32'h1F);
        if (ok) begin
            poll(1, 32'h3, r);
            check("up status", r, 32'h1);
            rd(1, `AG_GRANT, r);
            check("up grant", r, {7'h0, !aux[19], ty, cl});
            check("up irq", {31'h0, irq[1]}, 32'h1);
            wr(1, `AG_STAT, 32'h1F);
            used_cl[cl] = 1'b1;
            n_ok++;
        end else begin
            rd(1, `AG_STAT, r);
            check("up quiet", r, 32'h0);
        end
    endtask
    task automatic cap(input logic [6:0] mx, input logic [6:0] us);
        logic [31:0] r;
        logic [6:0] em;
        logic [6:0] eu;
        em = mx < 7'h01 ? 7'h01 : (mx > 7'h63 ? 7'h63 : mx);
        eu = us > em ? em : us;
        wr(0, `AG_CAP, {17'h0, us, 1'b0, mx});
        wr(1, `AG_CTRL, 32'h1);
        poll(1, 32'hC, r);
        check("reply status", r, 32'h4);
        rd(1, `AG_CAP, r);
        check("reply counts", r, {17'h0, eu, 1'b0, em});
        rd(1, `AG_CTRL, r);
        check("query open", r, 32'h0);
        rd(0, `AG_STAT, r);
        check("down cap status", r, {28'h0, em != mx || eu != us, 3'h4});
        wr(0, `AG_STAT, 32'h1F);
        wr(1, `AG_STAT, 32'h1F);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        logic [31:0] r;
        hresetn = 1'b0;
        ce = 1'b1;
        sess = 1'b0;
        hsel = 2'b00;
        hwrite = 2'b00;
        haddr = '{default: 32'h0};
        htrans = '{default: 2'b00};
        hwdata = '{default: 32'h0};
        seed = 32'h45C152F3;
        used_cl = '0;
        errors = 0;
        checks_done = 0;
        n_ok = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(0, `AG_CAP, r);
        check("down cap reset", r, 32'h1);
        rd(1, 32'h100, r);
        check("unmapped read", r, 32'h0);
        wr(0, `AG_MASK, 32'h2);
        wr(1, `AG_MASK, 32'h1);
        grant(8'h05, 16'h0001);
        wr(0, `AG_CTRL, 32'h1);
        sess = 1'b1;
        grant(8'h00, 16'h0001);
        grant(8'hFF, 16'hFFFF);
        grant(8'h01, 16'h0001);
        grant(8'hFE, 16'hFFFF);
        grant(8'h01, 16'h8000);
        grant(8'h22, 16'h0000);
        repeat (10) grant(8'(rnd() & 32'h1F), 16'(rnd()));
        rd(0, `AG_AUX, r);
        check("grant count", r, 32'(n_ok));
        wr(0, `AG_CTRL, 32'h0);
        sess = 1'b0;
        used_cl = '0;
        wr(0, `AG_CTRL, 32'h1);
        sess = 1'b1;
        grant(8'h01, 16'h0003);
        cap(7'h01, 7'h00);
        cap(7'h63, 7'h63);
        cap(7'h09, 7'h09);
        cap(7'h0A, 7'h03);
        cap(7'h00, 7'h00);
        cap(7'h32, 7'h46);
        cap(7'h78, 7'h05);
        for (int i = 0; i < 6; i++) begin
            r = rnd() % 99 + 1;
            cap(7'(r), 7'(rnd() % (r + 1)));
        end
        rd(0, `AG_STAT, r);
        check("irq idle", {30'h0, irq}, 32'h0);
        test_done();
    end
endmodule
